// ### logic/dpc_regs.v
`timescale 1ns/100ps
`include "dpc_regs.vh"
////////////////////////////////////////////////////////////////////////////////
module dpc_regs (
  // clock and reset
  input  wire       core_clk,
  input  wire       rst,
  // serial port register access
  input  wire [6:0] reg_addr,
  input  wire       reg_wr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  // dll status inputs
  input  wire       dll_lock,
  input  wire       dll_start_warn,
  input  wire       dll_end_warn,
  input  wire       dll_correct_phase,
  input  wire       data_clock_input_on,
  input  wire       dll_lock_negative,
  input  wire       dll_running,
  // fifo side
  input  wire       frame_pin,
  input  wire [2:0] fill0,
  input  wire [2:0] fill1,
  input  wire [2:0] fill2,
  input  wire [2:0] fill3,
  output reg        fifo_reset,
  output wire [2:0] read_pointer_offset,
  output wire [2:0] write_pointer_offset,
  // data path controls
  output wire       interp_filter_en,
  output wire       unsigned_format,
  output wire       filter_rejection_select,
  output wire       mix_decode_en,
  output wire       sync_out_en,
  output wire [2:0] sync_phase_delay,
  output wire [9:0] gain_code
);
  ////////////////////////////////////////////////////////////////////////////
  // storage
  reg  [7:0] fifo_control;
  reg  [7:0] fifo_pointer_offset;
  reg  [2:0] sample_format_control;
  reg        decoder_mode_control;
  reg        sync_enable;
  reg        inc_pulse;
  reg        dec_pulse;
  reg  [7:0] gain_code_low;
  reg  [1:0] gain_code_high;
  reg        req_seen;
  reg  [7:0] receiver_lock_status;
  wire [6:0] fifo_phase0_level;
  wire [6:0] fifo_phase1_level;
  wire [6:0] fifo_phase2_level;
  wire [6:0] fifo_phase3_level;
  wire       sync_done;
  wire [2:0] phase_now;
  wire       req_bit;
  wire       wr_fifo;
  // full-width reset images, sliced down to the stored fields
  localparam [7:0] FMT_RST  = `DPC_RST_FORMAT_CTRL;
  localparam [7:0] DEC_RST  = `DPC_RST_DECODE_CTRL;
  localparam [7:0] SYNC_RST = `DPC_RST_SYNC;

  assign req_bit = fifo_control[`DPC_FIFO_REQ_BIT];
  assign wr_fifo = reg_wr && (reg_addr == `DPC_ADDR_FIFO_CTRL);

  ////////////////////////////////////////////////////////////////////////////
  // register writes; reserved bits not stored
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fifo_control          <= `DPC_RST_FIFO_CTRL;
      fifo_pointer_offset   <= `DPC_RST_FIFO_OFFSET;
      sample_format_control <= FMT_RST[7:5];
      decoder_mode_control  <= DEC_RST[0];
      sync_enable           <= SYNC_RST[`DPC_SYNC_EN_BIT];
      inc_pulse             <= 1'b0;
      dec_pulse             <= 1'b0;
      gain_code_low         <= `DPC_RST_GAIN_LOW;
      gain_code_high        <= `DPC_RST_GAIN_HIGH;
    end else begin
      inc_pulse <= 1'b0;
      dec_pulse <= 1'b0;
      if (wr_fifo) begin
        fifo_control[`DPC_FIFO_REQ_BIT]    <= reg_wdata[`DPC_FIFO_REQ_BIT];
        fifo_control[`DPC_FIFO_PIN_BIT]    <= reg_wdata[`DPC_FIFO_PIN_BIT];
        fifo_control[`DPC_FIFO_REPORT_BIT] <= reg_wdata[`DPC_FIFO_REPORT_BIT];
      end
      // ack follows request one cycle after it changes, on the same edge as the fifo reset from a rising request
      if (req_bit != req_seen)
        fifo_control[`DPC_FIFO_ACK_BIT] <= req_bit;
      if (reg_wr) begin
        case (reg_addr)
          `DPC_ADDR_FIFO_OFFSET: fifo_pointer_offset <= {1'b0, reg_wdata[6:4], 1'b0, reg_wdata[2:0]};
          `DPC_ADDR_FORMAT_CTRL: sample_format_control <= reg_wdata[7:5];
          `DPC_ADDR_DECODE_CTRL: decoder_mode_control <= reg_wdata[0];
          `DPC_ADDR_SYNC: begin
            sync_enable <= reg_wdata[`DPC_SYNC_EN_BIT];
            inc_pulse   <= reg_wdata[`DPC_SYNC_INC_BIT];
            dec_pulse   <= reg_wdata[`DPC_SYNC_DEC_BIT] & ~reg_wdata[`DPC_SYNC_INC_BIT];
          end
          `DPC_ADDR_GAIN_LOW:  gain_code_low <= reg_wdata;
          `DPC_ADDR_GAIN_HIGH: gain_code_high <= reg_wdata[1:0];
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fifo alignment: request going 0 to 1 or enabled framing pin resets the fifo
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      req_seen   <= 1'b0;
      fifo_reset <= 1'b0;
    end else begin
      req_seen   <= req_bit;
      fifo_reset <= ((req_bit != req_seen) && req_bit)
                    || (fifo_control[`DPC_FIFO_PIN_BIT] && frame_pin);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receiver status snapshot, zero after reset
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      receiver_lock_status <= 8'h00;
    end else begin
      receiver_lock_status <= {dll_lock,
                               dll_start_warn | dll_end_warn,
                               dll_start_warn,
                               dll_end_warn,
                               dll_correct_phase,
                               data_clock_input_on,
                               dll_lock_negative,
                               dll_running};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sub-blocks
  dpc_thermo #(
    .WIDTH (7)
  ) u_thermo (
    .core_clk  (core_clk),
    .rst       (rst),
    .report_en (fifo_control[`DPC_FIFO_REPORT_BIT]),
    .fill0     (fill0),
    .fill1     (fill1),
    .fill2     (fill2),
    .fill3     (fill3),
    .level0    (fifo_phase0_level),
    .level1    (fifo_phase1_level),
    .level2    (fifo_phase2_level),
    .level3    (fifo_phase3_level)
  );

  dpc_sync_step u_sync (
    .core_clk    (core_clk),
    .rst         (rst),
    .inc_req     (inc_pulse),
    .dec_req     (dec_pulse),
    .phase_delay (phase_now),
    .step_done   (sync_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs to the data path
  assign read_pointer_offset     = fifo_pointer_offset[6:4];
  assign write_pointer_offset    = fifo_pointer_offset[2:0];
  assign interp_filter_en        = sample_format_control[2];
  assign unsigned_format         = sample_format_control[1];
  assign filter_rejection_select = sample_format_control[0];
  assign mix_decode_en           = decoder_mode_control;
  assign sync_out_en             = sync_enable;
  assign sync_phase_delay        = phase_now;
  assign gain_code               = {gain_code_high, gain_code_low};

  ////////////////////////////////////////////////////////////////////////////
  // read mux, registered; unmapped reads zero
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `DPC_ADDR_RX_STATUS:   reg_rdata <= receiver_lock_status;
        `DPC_ADDR_FIFO_CTRL:   reg_rdata <= {fifo_control[7:5], 4'h0, fifo_control[0]};
        `DPC_ADDR_FIFO_OFFSET: reg_rdata <= fifo_pointer_offset;
        `DPC_ADDR_PH0_LEVEL:   reg_rdata <= {1'b0, fifo_phase0_level};
        `DPC_ADDR_PH1_LEVEL:   reg_rdata <= {1'b0, fifo_phase1_level};
        `DPC_ADDR_PH2_LEVEL:   reg_rdata <= {1'b0, fifo_phase2_level};
        `DPC_ADDR_PH3_LEVEL:   reg_rdata <= {1'b0, fifo_phase3_level};
        `DPC_ADDR_FORMAT_CTRL: reg_rdata <= {sample_format_control, 5'h00};
        `DPC_ADDR_DECODE_CTRL: reg_rdata <= {7'h00, decoder_mode_control};
        `DPC_ADDR_SYNC:        reg_rdata <= {3'h0, sync_enable, sync_done, phase_now};
        `DPC_ADDR_GAIN_LOW:    reg_rdata <= gain_code_low;
        `DPC_ADDR_GAIN_HIGH:   reg_rdata <= {6'h00, gain_code_high};
        default:               reg_rdata <= 8'h00;
      endcase
    end
  end
endmodule // dpc_regs

// ### pkg/dpc_regs.vh
`ifndef DPC_REGS_VH
`define DPC_REGS_VH
// register offsets
`define DPC_ADDR_RX_STATUS     7'h0e
`define DPC_ADDR_FIFO_CTRL     7'h11
`define DPC_ADDR_FIFO_OFFSET   7'h12
`define DPC_ADDR_PH0_LEVEL     7'h13
`define DPC_ADDR_PH1_LEVEL     7'h14
`define DPC_ADDR_PH2_LEVEL     7'h15
`define DPC_ADDR_PH3_LEVEL     7'h16
`define DPC_ADDR_FORMAT_CTRL   7'h18
`define DPC_ADDR_DECODE_CTRL   7'h19
`define DPC_ADDR_SYNC          7'h1a
`define DPC_ADDR_GAIN_LOW      7'h20
`define DPC_ADDR_GAIN_HIGH     7'h21
// reset values
`define DPC_RST_FIFO_CTRL      8'h00
`define DPC_RST_FIFO_OFFSET    8'h04
`define DPC_RST_FORMAT_CTRL    8'h00
`define DPC_RST_DECODE_CTRL    8'h00
`define DPC_RST_SYNC           8'h00
`define DPC_RST_GAIN_LOW       8'h00
`define DPC_RST_GAIN_HIGH      2'h2
// field positions
`define DPC_FIFO_REQ_BIT       7
`define DPC_FIFO_ACK_BIT       6
`define DPC_FIFO_PIN_BIT       5
`define DPC_FIFO_REPORT_BIT    0
`define DPC_FMT_FILTER_BIT     7
`define DPC_FMT_BINARY_BIT     6
`define DPC_FMT_REJECT_BIT     5
`define DPC_SYNC_INC_BIT       7
`define DPC_SYNC_DEC_BIT       6
`define DPC_SYNC_EN_BIT        4
// timing: cycles a latency step takes to complete
`define DPC_SYNC_STEP_CYCLES   4'h4
// reset value of the phase thermometers
`define DPC_RST_LEVEL          7'h00
`endif

// ### logic/dpc_sync_step.v
`timescale 1ns/100ps
`include "dpc_regs.vh"
// steps the sync phase delay up or down, one step per request taken while idle
module dpc_sync_step (
  // clock and reset
  input  wire       core_clk,
  input  wire       rst,
  // requests
  input  wire       inc_req,
  input  wire       dec_req,
  // status
  output reg  [2:0] phase_delay,
  output reg        step_done
);
  reg [3:0] busy_cnt;
  reg       pend_inc;
  // step engine: a request waits a fixed count, then applies
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      phase_delay <= 3'h0;
      step_done   <= 1'b0;
      busy_cnt    <= 4'h0;
      pend_inc    <= 1'b0;
    end else if (busy_cnt != 4'h0) begin
      busy_cnt <= busy_cnt - 4'h1;
      if (busy_cnt == 4'h1) begin
        phase_delay <= pend_inc ? phase_delay + 3'h1 : phase_delay - 3'h1;
        step_done   <= 1'b1;
      end
    end else if (inc_req || dec_req) begin
      busy_cnt  <= `DPC_SYNC_STEP_CYCLES;
      pend_inc  <= inc_req;
      step_done <= 1'b0;
    end
  end
endmodule // dpc_sync_step

// ### logic/dpc_thermo.v
`timescale 1ns/100ps
`include "dpc_regs.vh"
// holds the four phase fill thermometers, refreshed only while reporting is on
module dpc_thermo #(
  parameter WIDTH = 7
) (
  // clock and reset
  input  wire               core_clk,
  input  wire               rst,
  // control
  input  wire               report_en,
  // fill levels from the fifo, as binary counts
  input  wire [2:0]         fill0,
  input  wire [2:0]         fill1,
  input  wire [2:0]         fill2,
  input  wire [2:0]         fill3,
  // thermometer status
  output reg  [WIDTH-1:0]   level0,
  output reg  [WIDTH-1:0]   level1,
  output reg  [WIDTH-1:0]   level2,
  output reg  [WIDTH-1:0]   level3
);
  // count to thermometer: n ones from the bottom, 4 marks the middle
  function [WIDTH-1:0] therm;
    input [2:0] n;
    integer i;
    begin
      therm = {WIDTH{1'b0}};
      for (i = 0; i < WIDTH; i = i + 1)
        if (i < n) therm[i] = 1'b1;
    end
  endfunction
  // refresh only while reporting enabled
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      level0 <= `DPC_RST_LEVEL;
      level1 <= `DPC_RST_LEVEL;
      level2 <= `DPC_RST_LEVEL;
      level3 <= `DPC_RST_LEVEL;
    end else if (report_en) begin
      level0 <= therm(fill0);
      level1 <= therm(fill1);
      level2 <= therm(fill2);
      level3 <= therm(fill3);
    end
  end
endmodule // dpc_thermo

// ### bench/dpc_regs_assertions.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// port-level checks for the data path register group
module dpc_regs_chk (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       rst,
  // register access
  input wire logic [6:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  // fifo side
  input wire logic       frame_pin,
  input wire logic       fifo_reset,
  input wire logic [2:0] read_pointer_offset,
  input wire logic [2:0] write_pointer_offset,
  // data path controls
  input wire logic       interp_filter_en,
  input wire logic       unsigned_format,
  input wire logic       filter_rejection_select,
  input wire logic       mix_decode_en,
  input wire logic       sync_out_en,
  input wire logic [2:0] sync_phase_delay,
  input wire logic [9:0] gain_code
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic req_q;
  logic pin_q;
  wire  w11 = reg_wr && reg_addr == 7'h11;
  // shadow of request and pin enable, so edges of the request are known
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      req_q <= 1'b0;
      pin_q <= 1'b0;
    end else if (w11) begin
      req_q <= reg_wdata[7];
      pin_q <= reg_wdata[5];
    end
  end
  chk_offset_write: assert property (reg_wr && reg_addr == 7'h12 |=>
    {read_pointer_offset, write_pointer_offset} == {$past(reg_wdata[6:4]), $past(reg_wdata[2:0])})
    else $error("pointer offsets differ from write");
  chk_format_write: assert property (reg_wr && reg_addr == 7'h18 |=>
    {interp_filter_en, unsigned_format, filter_rejection_select} == $past(reg_wdata[7:5]))
    else $error("format controls differ from write");
  chk_decode_write: assert property (reg_wr && reg_addr == 7'h19 |=> mix_decode_en == $past(reg_wdata[0]))
    else $error("decode mode differs from write");
  chk_sync_enable: assert property (reg_wr && reg_addr == 7'h1a |=> sync_out_en == $past(reg_wdata[4]))
    else $error("sync output enable differs from write");
  chk_gain_low: assert property (reg_wr && reg_addr == 7'h20 |=> gain_code[7:0] == $past(reg_wdata))
    else $error("gain low bits differ from write");
  chk_gain_high: assert property (reg_wr && reg_addr == 7'h21 |=> gain_code[9:8] == $past(reg_wdata[1:0]))
    else $error("gain high bits differ from write");
  chk_phase_step: assert property (sync_phase_delay != $past(sync_phase_delay) |->
    3'(sync_phase_delay - $past(sync_phase_delay)) inside {3'h1, 3'h7})
    else $error("phase delay moved by more than one step");
  chk_align_pulse: assert property (w11 && reg_wdata[7] && !req_q |-> ##[1:3] fifo_reset)
    else $error("alignment request gave no fifo reset");
  chk_pin_framing: assert property (frame_pin && pin_q |-> ##[1:3] fifo_reset)
    else $error("framing pin gave no fifo reset");
  cov_align: cover property (w11 && reg_wdata[7] && !req_q ##3 1'b1);
  cov_step: cover property (sync_phase_delay != $past(sync_phase_delay));
  cov_pin: cover property (frame_pin && pin_q ##1 fifo_reset);
endmodule // dpc_regs_chk

bind dpc_regs dpc_regs_chk chk_u (
  .core_clk                (core_clk),
  .rst                     (rst),
  .reg_addr                (reg_addr),
  .reg_wr                  (reg_wr),
  .reg_wdata               (reg_wdata),
  .frame_pin               (frame_pin),
  .fifo_reset              (fifo_reset),
  .read_pointer_offset     (read_pointer_offset),
  .write_pointer_offset    (write_pointer_offset),
  .interp_filter_en        (interp_filter_en),
  .unsigned_format         (unsigned_format),
  .filter_rejection_select (filter_rejection_select),
  .mix_decode_en           (mix_decode_en),
  .sync_out_en             (sync_out_en),
  .sync_phase_delay        (sync_phase_delay),
  .gain_code               (gain_code)
);

// ### bench/dpc_host_model.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// far side: dll status lines, framing pin and fill counts, moved on request
module dpc_host_model (
  // clock
  input  wire logic        core_clk,
  // requested state
  input  wire logic [6:0]  dll_set,
  input  wire logic [11:0] fill_set,
  input  wire logic        pin_set,
  // lines toward the device
  output wire logic [6:0]  dll_lines,
  output wire logic [11:0] fills,
  output wire logic        frame_pin
);
  logic [19:0] q = 20'h00000;
  // launched just after the edge, like a registered source
  always @(posedge core_clk) begin
    q <= #1 {pin_set, fill_set, dll_set};
  end
  assign {frame_pin, fills, dll_lines} = q;
endmodule // dpc_host_model

// ### bench/tb_top.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
module tb_top;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [6:0]  reg_addr = 7'h00;
  logic        reg_wr = 1'b0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_rd = 1'b0;
  logic [6:0]  dll_set = 7'h00;
  logic [11:0] fill_set = 12'h000;
  logic [11:0] hold;
  logic        pin_set = 1'b0;
  wire  [7:0]  reg_rdata;
  wire  [6:0]  dl;
  wire  [11:0] fl;
  wire         frame_pin, fifo_reset, interp_filter_en, unsigned_format, filter_rejection_select;
  wire         mix_decode_en, sync_out_en;
  wire  [2:0]  read_pointer_offset, write_pointer_offset, sync_phase_delay;
  wire  [9:0]  gain_code;
  int          err_count = 0;
  int          checked = 0;
  int          n;
  logic [7:0]  rv, x;
  logic [6:0]  a;
  logic [6:0]  ra [13] = '{7'h0e, 7'h11, 7'h12, 7'h13, 7'h14, 7'h15, 7'h16, 7'h18, 7'h19, 7'h1a, 7'h20, 7'h21, 7'h17};
  logic [7:0]  rr [13] = '{8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00};
  logic [6:0]  wa [5] = '{7'h12, 7'h18, 7'h19, 7'h20, 7'h21};
  dpc_regs dut_u (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dll_lock(dl[6]), .dll_start_warn(dl[5]), .dll_end_warn(dl[4]),
    .dll_correct_phase(dl[3]), .data_clock_input_on(dl[2]), .dll_lock_negative(dl[1]), .dll_running(dl[0]),
    .frame_pin(frame_pin), .fill0(fl[2:0]), .fill1(fl[5:3]), .fill2(fl[8:6]), .fill3(fl[11:9]),
    .fifo_reset(fifo_reset), .read_pointer_offset(read_pointer_offset), .write_pointer_offset(write_pointer_offset),
    .interp_filter_en(interp_filter_en), .unsigned_format(unsigned_format), .mix_decode_en(mix_decode_en),
    .filter_rejection_select(filter_rejection_select), .sync_out_en(sync_out_en),
    .sync_phase_delay(sync_phase_delay), .gain_code(gain_code));
  dpc_host_model host_u (.core_clk(core_clk), .dll_set(dll_set), .fill_set(fill_set), .pin_set(pin_set),
    .dll_lines(dl), .fills(fl), .frame_pin(frame_pin));
  // 40 MHz clock
  initial forever #12.5 core_clk = ~core_clk;
  // compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // register write and read cycles
  task automatic wr(input logic [6:0] ad, input logic [7:0] d);
    @(posedge core_clk);
    #1 reg_addr = ad;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge core_clk);
    #1 reg_wr = 1'b0;
  endtask
  task automatic rdchk(input logic [6:0] ad, input logic [7:0] m, input logic [7:0] e);
    @(posedge core_clk);
    #1 reg_addr = ad;
    reg_rd = 1'b1;
    @(posedge core_clk);
    #1 reg_rd = 1'b0;
    @(posedge core_clk);
    #1 chk(reg_rdata & m, e);
  endtask
  // fifo reset cycles seen over six clocks
  task automatic cnt(output int c);
    c = 0;
    repeat (6) begin
      @(posedge core_clk);
      #1 c += int'(fifo_reset);
    end
  endtask
  // wait out a latency step, then look at the sync register and ports
  task automatic step(input logic [7:0] e);
    repeat (8) @(posedge core_clk);
    rdchk(7'h1a, 8'h3f, e);
    chk({sync_out_en, sync_phase_delay}, {e[4], e[2:0]});
  endtask
  // expectations
  function automatic logic [7:0] wmask(input logic [6:0] ad);
    case (ad)
      7'h12: return 8'h77;
      7'h18: return 8'he0;
      7'h19: return 8'h01;
      7'h21: return 8'h03;
      default: return 8'hff;
    endcase
  endfunction
  function automatic logic [7:0] pview(input logic [6:0] ad);
    case (ad)
      7'h12: return {1'b0, read_pointer_offset, 1'b0, write_pointer_offset};
      7'h18: return {interp_filter_en, unsigned_format, filter_rejection_select, 5'h00};
      7'h19: return {7'h00, mix_decode_en};
      7'h20: return gain_code[7:0];
      default: return {6'h00, gain_code[9:8]};
    endcase
  endfunction
  function automatic logic [7:0] therm(input logic [2:0] v);
    return 8'((9'h001 << v) - 9'h001);
  endfunction
  // report and end the run
  task automatic conclude;
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // watchdog
  initial begin
    #(25 * 8000);
    err_count++;
    conclude();
  end
  // main sequence
  initial begin
    int seed;
    seed = $urandom(32'hbe30);
    repeat (6) @(posedge core_clk);
    #1 rst = 1'b0;
    foreach (ra[i]) rdchk(ra[i], 8'hff, rr[i]);
    chk({gain_code, write_pointer_offset}, {10'h200, 3'h4});
    // corner then random writes, read back and port views
    for (int i = 0; i < 30; i++) begin
      a = wa[i % 5];
      x = i < 5 ? 8'hff : i < 10 ? 8'h00 : 8'($urandom);
      wr(a, x);
      rdchk(a, 8'hff, x & wmask(a));
      chk(pview(a), x & wmask(a));
    end
    // status snapshots, then a write that must not land
    for (int i = 0; i < 10; i++) begin
      dll_set = i == 0 ? 7'h7f : i == 1 ? 7'h10 : 7'($urandom);
      repeat (4) @(posedge core_clk);
      rdchk(7'h0e, 8'hff, {dll_set[6], dll_set[5] | dll_set[4], dll_set[5:0]});
    end
    wr(7'h0e, ~{dll_set[6], dll_set[5] | dll_set[4], dll_set[5:0]});
    rdchk(7'h0e, 8'hff, {dll_set[6], dll_set[5] | dll_set[4], dll_set[5:0]});
    // register alignment request and acknowledge
    wr(7'h11, 8'h80);
    cnt(n);
    chk(16'(n), 16'h1);
    rdchk(7'h11, 8'hff, 8'hc0);
    wr(7'h11, 8'h00);
    repeat (3) @(posedge core_clk);
    rdchk(7'h11, 8'hff, 8'h00);
    // framing pin only acts when enabled
    pin_set = 1'b1;
    cnt(n);
    chk(16'(n), 16'h0);
    wr(7'h11, 8'h20);
    cnt(n);
    chk(n != 0, 1'b1);
    pin_set = 1'b0;
    // thermometers update while reporting, hold when off
    fill_set = 12'he15;
    wr(7'h11, 8'h01);
    repeat (3) @(posedge core_clk);
    for (int i = 0; i < 4; i++) rdchk(7'(7'h13 + i), 8'hff, therm(fill_set[3*i +: 3]));
    wr(7'h11, 8'h00);
    hold = fill_set;
    fill_set = 12'($urandom);
    repeat (3) @(posedge core_clk);
    for (int i = 0; i < 4; i++) rdchk(7'(7'h13 + i), 8'hff, therm(hold[3*i +: 3]));
    // latency steps: busy request ignored, wrap below zero, both bits set
    wr(7'h1a, 8'h90);
    wr(7'h1a, 8'h90);
    step(8'h19);
    wr(7'h1a, 8'h50);
    step(8'h18);
    wr(7'h1a, 8'h40);
    step(8'h0f);
    wr(7'h1a, 8'hc0);
    @(posedge core_clk);
    rdchk(7'h1a, 8'h0f, 8'h07);
    step(8'h08);
    conclude();
  end
endmodule // tb_top
